// File: src/frt_pkg.sv
// package for the free-running timer counter core: register map, fields, reset values
// assumes an apb slave with 32-bit data, one register per aligned word
// Functional notes
// - 16-bit up-counter advanced by prescaler or by external edges, seen as high and low bytes
// - timer clock is cpu clock /2, /4, /8 or external input
// - primary and alternate views always return the same count
// - any write to either low byte view forces counter to fffc
// - counter starts at fffc after reset; fffc is the only reload value
// - reading high byte first captures the low byte into a buffer
// - buffered low byte stays frozen until low byte read completes sequence
// - with no sequence pending, low byte read returns live low byte
// - wrap from ffff to 0000 sets overflow flag in status register
// - overflow requests interrupt only while enabled and cpu mask clear
// - overflow flag cleared by status read then access to primary low byte
// - alternate low byte accesses never clear the overflow flag
// - counter keeps running unchanged in wait mode
// - in halt the counter stops and resumes from held count
// - external clock selected when both clock select bits are one
// - edge select bit picks rising or falling external edge
// - external updates are synchronised to the cpu clock
// - unbonded timer input reads as logic one
// - two instances share nothing and count in step after reset
// - flash variant: capture2 and compare2 flags held at zero
package frt_pkg;

  // register byte addresses
  localparam logic [7:0] FRT_OFS_CTRL_ONE  = 8'h00;
  localparam logic [7:0] FRT_OFS_CTRL_TWO  = 8'h04;
  localparam logic [7:0] FRT_OFS_STATUS    = 8'h08;
  localparam logic [7:0] FRT_OFS_CNT_HIGH  = 8'h0c;
  localparam logic [7:0] FRT_OFS_CNT_LOW   = 8'h10;
  localparam logic [7:0] FRT_OFS_ALT_HIGH  = 8'h14;
  localparam logic [7:0] FRT_OFS_ALT_LOW   = 8'h18;

  // timer_control_one fields
  localparam int FRT_BIT_OVF_IRQ_EN = 5;
  // timer_control_two fields
  localparam int FRT_BIT_CLK_SEL_LO = 2;
  localparam int FRT_BIT_CLK_SEL_HI = 3;
  localparam int FRT_BIT_EXT_EDGE   = 0;
  // timer_status_register fields
  localparam int FRT_BIT_CAP2_FLAG  = 4;
  localparam int FRT_BIT_OVF_FLAG   = 5;
  localparam int FRT_BIT_CMP2_FLAG  = 3;

  // clock select encodings
  localparam logic [1:0] FRT_CLK_DIV4 = 2'h0;
  localparam logic [1:0] FRT_CLK_DIV2 = 2'h1;
  localparam logic [1:0] FRT_CLK_DIV8 = 2'h2;
  localparam logic [1:0] FRT_CLK_EXT  = 2'h3;

  localparam logic [15:0] FRT_RELOAD_VAL = 16'hfffc;
  localparam logic [15:0] FRT_WRAP_VAL   = 16'hffff;
  localparam logic [7:0]  FRT_CTRL_RST   = 8'h00;
  localparam logic [2:0]  FRT_PRESC_MAX8 = 3'h7;
  localparam logic [2:0]  FRT_PRESC_MAX4 = 3'h3;
  localparam logic [2:0]  FRT_PRESC_MAX2 = 3'h1;

endpackage

// File: src/frt_timer.sv
// free-running 16-bit timer counter core with apb register access
// assumes pclk is the cpu clock; ext_count_in is asynchronous to it
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module frt_timer
  import frt_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system
  input  wire logic        halt_mode,
  input  wire logic        cpu_irq_mask,
  input  wire logic        ext_pin_bonded,
  input  wire logic        ext_count_in,
  // request
  output logic             timer_irq
);

  typedef struct packed {
    logic [15:0] count;
    logic [2:0]  presc;
    logic [7:0]  low_buf;
    logic        seq_pend;
    logic        ovf_flag;
    logic        ovf_armed;
    logic        ovf_irq_en;
    logic [1:0]  clk_sel;
    logic        ext_edge;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic [31:0] rdata;
    logic        rd_hold;
  } frt_state_s;

  frt_state_s st_r;
  frt_state_s st_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        tick;
  logic        ext_lvl;
  logic [2:0]  pmax;
  logic [7:0]  st_byte;

  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign mapped = hit(paddr, FRT_OFS_CTRL_ONE) | hit(paddr, FRT_OFS_CTRL_TWO) |
                  hit(paddr, FRT_OFS_STATUS)   | hit(paddr, FRT_OFS_CNT_HIGH) |
                  hit(paddr, FRT_OFS_CNT_LOW)  | hit(paddr, FRT_OFS_ALT_HIGH) |
                  hit(paddr, FRT_OFS_ALT_LOW);
  // reads take one wait state so that registered read data stands at the ready edge
  assign pready  = ~rd | st_r.rd_hold;
  assign pslverr = acc & ~mapped & pready;
  assign prdata  = st_r.rdata;
  assign timer_irq = st_r.ovf_flag & st_r.ovf_irq_en & ~cpu_irq_mask;
  assign ext_lvl = ext_pin_bonded ? ext_count_in : 1'b1;

  always_comb begin
    case (st_r.clk_sel)
      FRT_CLK_DIV2: pmax = FRT_PRESC_MAX2;
      FRT_CLK_DIV8: pmax = FRT_PRESC_MAX8;
      default:      pmax = FRT_PRESC_MAX4;
    endcase
  end

  always_comb begin
    st_byte = 8'h00;
    st_byte[FRT_BIT_OVF_FLAG] = st_r.ovf_flag;
    st_byte[FRT_BIT_CAP2_FLAG] = 1'b0;
    st_byte[FRT_BIT_CMP2_FLAG] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    tick   = 1'b0;
    // two-flop sync, third stage for edge detect only
    st_nxt.ext_s1 = ext_lvl;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;

    // halt freezes prescaler and count; wait has no input here
    if (!halt_mode) begin
      // both select bits give external clock
      if (st_r.clk_sel == FRT_CLK_EXT) begin
        tick = st_r.ext_edge ? (st_r.ext_s2 & ~st_r.ext_s3)
                             : (~st_r.ext_s2 & st_r.ext_s3);
      end else begin
        if (st_r.presc >= pmax) begin
          st_nxt.presc = 3'h0;
          tick = 1'b1;
        end else begin
          st_nxt.presc = st_r.presc + 3'h1;
        end
      end
    end

    if (tick) begin
      st_nxt.count = st_r.count + 16'h0001;
    end

    // read data is loaded in the first access cycle and held through the wait state
    st_nxt.rd_hold = rd & ~st_r.rd_hold;
    if (!rd) begin
      st_nxt.rdata = 32'h0;
    end
    if (rd && !st_r.rd_hold) begin
      case (1'b1)
        hit(paddr, FRT_OFS_CTRL_ONE): st_nxt.rdata[FRT_BIT_OVF_IRQ_EN] = st_r.ovf_irq_en;
        hit(paddr, FRT_OFS_CTRL_TWO): begin
          st_nxt.rdata[FRT_BIT_CLK_SEL_HI:FRT_BIT_CLK_SEL_LO] = st_r.clk_sel;
          st_nxt.rdata[FRT_BIT_EXT_EDGE] = st_r.ext_edge;
        end
        hit(paddr, FRT_OFS_STATUS): begin
          st_nxt.rdata[7:0] = st_byte;
          if (st_r.ovf_flag) begin
            st_nxt.ovf_armed = 1'b1;
          end
        end
        // both high views capture the low byte
        hit(paddr, FRT_OFS_CNT_HIGH), hit(paddr, FRT_OFS_ALT_HIGH): begin
          st_nxt.rdata[7:0] = st_r.count[15:8];
          if (!st_r.seq_pend) begin
            st_nxt.low_buf  = st_r.count[7:0];
            st_nxt.seq_pend = 1'b1;
          end
        end
        hit(paddr, FRT_OFS_CNT_LOW), hit(paddr, FRT_OFS_ALT_LOW): begin
          // live low byte when nothing pending
          st_nxt.rdata[7:0] = st_r.seq_pend ? st_r.low_buf : st_r.count[7:0];
          st_nxt.seq_pend   = 1'b0;
        end
        default: st_nxt.rdata = 32'h0;
      endcase
    end

    if (wr) begin
      if (hit(paddr, FRT_OFS_CTRL_ONE)) begin
        st_nxt.ovf_irq_en = pwdata[FRT_BIT_OVF_IRQ_EN];
      end
      if (hit(paddr, FRT_OFS_CTRL_TWO)) begin
        st_nxt.clk_sel  = pwdata[FRT_BIT_CLK_SEL_HI:FRT_BIT_CLK_SEL_LO];
        st_nxt.ext_edge = pwdata[FRT_BIT_EXT_EDGE];
        st_nxt.presc    = 3'h0;
      end
      // any low byte write reloads fffc
      if (hit(paddr, FRT_OFS_CNT_LOW) || hit(paddr, FRT_OFS_ALT_LOW)) begin
        st_nxt.count = FRT_RELOAD_VAL;
        st_nxt.presc = 3'h0;
      end
    end

    // second step: primary low byte only
    if (acc && pready && hit(paddr, FRT_OFS_CNT_LOW) && st_r.ovf_armed) begin
      st_nxt.ovf_flag  = 1'b0;
      st_nxt.ovf_armed = 1'b0;
    end

    // wrap sets flag; set wins over clear
    if (tick && st_r.count == FRT_WRAP_VAL && st_nxt.count == 16'h0000) begin
      st_nxt.ovf_flag = 1'b1;
    end
  end

  // fixed reset count keeps instances in step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r            <= '0;
      st_r.count      <= FRT_RELOAD_VAL;
      st_r.clk_sel    <= FRT_CTRL_RST[1:0];
      st_r.ext_s1     <= 1'b1;
      st_r.ext_s2     <= 1'b1;
      st_r.ext_s3     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// File: sim/frt_timer_sva.sv
// checker on the apb and request ports of the timer core
// assumes apb reads with one wait state, read data standing at the ready edge
`timescale 1ns/1ps
module frt_timer_sva
  import frt_pkg::*;
(
  // watched ports
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halt_mode,
  input wire logic        cpu_irq_mask,
  input wire logic        timer_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  AST_READY: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  AST_ERR: assert property (psel && penable && pready |->
    pslverr == (paddr > FRT_OFS_ALT_LOW || paddr[1:0] != 2'h0)) else $error("bad pslverr");
  AST_MASK: assert property (cpu_irq_mask |-> !timer_irq) else $error("masked irq");
  AST_NOCAP2: assert property (psel && penable && pready && !pwrite && paddr == FRT_OFS_STATUS |->
    prdata[4:3] == 2'h0) else $error("capture2 or compare2 flag set");
  AST_HOLD: assert property (timer_irq && !psel ##1 !cpu_irq_mask |-> timer_irq)
    else $error("irq dropped without access");
  AST_ALTKEEP: assert property (timer_irq && psel && penable && paddr == FRT_OFS_ALT_LOW
    ##1 !cpu_irq_mask |-> timer_irq) else $error("alternate access cleared flag");
  AST_CLEAR: assert property (timer_irq && psel && penable && paddr == FRT_OFS_STATUS
    ##[1:6] psel && penable && pready && paddr == FRT_OFS_CNT_LOW |=> !timer_irq)
    else $error("no clear");
  AST_HALT: assert property (psel && penable && paddr == FRT_OFS_ALT_LOW && halt_mode
    && $past(psel && penable && paddr == FRT_OFS_CNT_LOW && halt_mode, 3)
    |=> prdata == $past(prdata, 3)) else $error("count moved in halt");
  cover property (timer_irq);
  cover property (psel && penable && halt_mode);
  cover property (psel && penable && pslverr);
endmodule
bind frt_timer frt_timer_sva frt_timer_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .halt_mode, .cpu_irq_mask, .timer_irq);

// File: sim/frt_ext_src.sv
// external count source at the timer's count pin
// assumes pclk is the cpu clock; the pin follows want at a legal pace
`timescale 1ns/1ps
module frt_ext_src (
  // clock and request
  input  wire logic pclk,
  input  wire logic want,
  // pin
  output logic      ext
);
  logic [2:0] gap_r = 3'h0;
  initial ext = 1'b0;
  // edge spacing: at least six cycles between pin changes; a want toggle undone within the gap is dropped
  always @(posedge pclk) begin
    if (gap_r != 3'h0) begin
      gap_r <= gap_r - 3'h1;
    end else if (want != ext) begin
      ext   <= want;
      gap_r <= 3'h5;
    end
  end
endmodule

// File: sim/frt_timer_bench.sv
// bench for the timer core: apb master, count source and scenarios
// assumes apb reads answer with pready after one wait state, data taken at that edge
`timescale 1ns/1ps
module frt_timer_bench;
  import frt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_irq;
  logic        halt_mode, cpu_irq_mask, ext_pin_bonded, want;
  wire logic   ext_count_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          errors, tests_run;
  always #20 pclk = ~pclk;
  frt_timer frt_timer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .halt_mode, .cpu_irq_mask, .ext_pin_bonded, .ext_count_in, .timer_irq);
  frt_ext_src frt_ext_src_i (.pclk, .want, .ext(ext_count_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      errors++;
    end
    r = prdata;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // edges per pulse counted once in either edge mode
  task automatic pulse(input int k);
    repeat (2 * k) begin
      want <= ~want;
      repeat (8) @(posedge pclk);
    end
  endtask
  task automatic t_reset;
    rc(FRT_OFS_CNT_HIGH, 32'hff);
    rc(FRT_OFS_CNT_LOW, 32'hfc);
    rc(FRT_OFS_CTRL_ONE, 32'h0);
    rc(FRT_OFS_CTRL_TWO, 32'h0);
    rc(8'h1c, 32'h0);
    xfer(1'b1, FRT_OFS_CTRL_TWO, 32'h0d);
    halt_mode <= 1'b0;
  endtask
  task automatic t_seq;
    pulse(1);
    xfer(1'b1, FRT_OFS_ALT_LOW, 32'ha5);
    pulse(2);
    rc(FRT_OFS_ALT_HIGH, 32'hff);
    pulse(1);
    rc(FRT_OFS_CNT_HIGH, 32'hff);
    rc(FRT_OFS_CNT_LOW, 32'hfe);
    rc(FRT_OFS_ALT_LOW, 32'hff);
  endtask
  task automatic t_ovf;
    xfer(1'b1, FRT_OFS_CTRL_ONE, 32'h20);
    pulse(1);
    rc(FRT_OFS_STATUS, 32'h20);
    chk({31'h0, timer_irq}, 32'h0);
    cpu_irq_mask <= 1'b0;
    @(posedge pclk);
    chk({31'h0, timer_irq}, 32'h1);
    rc(FRT_OFS_ALT_LOW, 32'h0);
    chk({31'h0, timer_irq}, 32'h1);
    rc(FRT_OFS_STATUS, 32'h20);
    xfer(1'b1, FRT_OFS_CNT_LOW, 32'h0);
    chk({31'h0, timer_irq}, 32'h0);
  endtask
  task automatic t_halt_edge;
    halt_mode <= 1'b1;
    pulse(2);
    rc(FRT_OFS_CNT_LOW, 32'hfc);
    rc(FRT_OFS_ALT_LOW, 32'hfc);
    halt_mode <= 1'b0;
    pulse(1);
    rc(FRT_OFS_ALT_LOW, 32'hfd);
    xfer(1'b1, FRT_OFS_CTRL_TWO, 32'h0c);
    pulse(1);
    rc(FRT_OFS_ALT_LOW, 32'hfe);
    ext_pin_bonded <= 1'b0;
    repeat (8) @(posedge pclk);
    ext_pin_bonded <= 1'b1;
    repeat (8) @(posedge pclk);
    rc(FRT_OFS_ALT_LOW, 32'hff);
  endtask
  task automatic close_out;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, want, paddr, pwdata} = 46'h0;
    {halt_mode, cpu_irq_mask, ext_pin_bonded} = 3'h7;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_seq;
    t_ovf;
    t_halt_edge;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    close_out;
  end
endmodule
